// ==== logic/fdc_perpendicular_lock_ctrl.sv ====
// perpendicular mode, lock and dump extension with a wishbone register port
//
// Behaviour
// - reset selects conventional, both selects zero
// - conventional read: vco enable at byte 24
// - 1 Mbps perpendicular read: vco enable at 43
// - vco point leaves two byte cushion
// - conventional write gate at sync field start
// - 1 Mbps perpendicular write covers 38 gap2 bytes
// - 500 Kbps perpendicular write covers 19 bytes
// - format gap2 41 in 1 Mbps perpendicular mode, else 22
// - drive 0 bit gives perpendicular when selects zero
// - per-drive gap2 follows programmed data rate
// - perpendicular drive gets zero precompensation
// - conventional drive uses programmed precompensation
// - drive bits change only with overwrite enable or hardware reset
// - global selects set make drive bits ignored
// - software reset clears the two selects but not the drive bits
// - hardware reset clears selects and drive bits
// - lock keeps fifo and track settings on soft reset
// - hardware reset clears lock, restores fifo defaults
// - lock returns one byte showing lock bit
// - dump eighth byte holds lock and perpendicular
// - hardware reset picks compatible mode from straps
// - defaults: fifo off, threshold zero, track zero
`timescale 1ns/1ps
module fdc_perpendicular_lock_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic hardware_reset_pin_i,
  input wire logic identity_select_i,
  input wire logic encoding_mode_select_i,
  input wire logic gap_start_i,
  input wire logic byte_tick_i,
  input wire logic read_op_i,
  input wire logic write_op_i,
  input wire logic op_done_i,
  output logic pll_vco_enable_o,
  output logic write_gate_o,
  output logic [5:0] gap2_len_o,
  output logic [2:0] precomp_o,
  output logic fifo_disable_setting_o,
  output logic [3:0] fifo_threshold_setting_o,
  output logic [7:0] precomp_start_track_o,
  output logic [1:0] compat_mode_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic ack_q;
  logic [31:0] dat_q;
  logic write_gate_timing_select_q;
  logic gap_select_q;
  logic [3:0] per_drive_perp_bits_q;
  logic lock_q;
  logic fifo_disable_setting_q;
  logic [3:0] fifo_threshold_setting_q;
  logic [7:0] precomp_start_track_q;
  logic [1:0] rate_q;
  logic [2:0] precomp_q;
  logic [1:0] compat_q;
  logic hw_rst_q;
  fdc_perp_pkg::timing_s timing_q;
  fdc_perp_pkg::timing_s timing_d;
  fdc_perp_pkg::rec_mode_e mode_d;
  logic drive_active_d;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire bus_req = cyc_i & stb_i & ~ack_q;
  wire wr_en = bus_req & we_i & sel_i[0];
  wire wr_en_hi = bus_req & we_i & sel_i[1];
  wire hit_perp = (adr_i == fdc_perp_pkg::OFS_PERP);
  wire hit_lock = (adr_i == fdc_perp_pkg::OFS_LOCK);
  wire hit_cfg = (adr_i == fdc_perp_pkg::OFS_CONFIG);
  wire hit_rate = (adr_i == fdc_perp_pkg::OFS_RATE);
  wire hit_swrst = (adr_i == fdc_perp_pkg::OFS_SWRST);
  wire hit_status = (adr_i == fdc_perp_pkg::OFS_STATUS);
  wire hit_dump = (adr_i == fdc_perp_pkg::OFS_DUMP8);
  wire wr_perp = wr_en & hit_perp;
  wire wr_lock = wr_en & hit_lock;
  wire wr_cfg_lo = wr_en & hit_cfg;
  wire wr_cfg_hi = wr_en_hi & hit_cfg;
  wire wr_rate = wr_en & hit_rate;
  wire sw_rst = wr_en & hit_swrst
    & (dat_i[fdc_perp_pkg::SWRST_DOR_BIT] | dat_i[fdc_perp_pkg::SWRST_DSR_BIT]);
  wire hw_rst = rst_i | hardware_reset_pin_i;
  wire cfg_default = hw_rst | (sw_rst & ~lock_q);
  wire ow_set = dat_i[fdc_perp_pkg::PERP_OW_BIT];

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  wire [7:0] perp_byte = {ow_set & 1'b0, 1'b0, per_drive_perp_bits_q,
    gap_select_q, write_gate_timing_select_q};
  wire [7:0] lock_result = {3'h0, lock_q, 4'h0};
  wire [7:0] dump8_byte = {lock_q, 1'b0, per_drive_perp_bits_q,
    gap_select_q, write_gate_timing_select_q};
  wire [15:0] cfg_word = {precomp_start_track_q, 3'h0,
    fifo_disable_setting_q, fifo_threshold_setting_q};
  wire [7:0] rate_byte = {3'h0, precomp_q, rate_q};
  wire [15:0] status_word = {compat_q, mode_d, drive_active_d, 4'h0, timing_q.gap2_len};
  wire [31:0] rd_mux =
    hit_perp ? {24'h000000, perp_byte} :
    hit_lock ? {24'h000000, lock_result} :
    hit_cfg ? {16'h0000, cfg_word} :
    hit_rate ? {24'h000000, rate_byte} :
    hit_status ? {16'h0000, status_word} :
    hit_dump ? {24'h000000, dump8_byte} :
    32'h00000000;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= bus_req;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_q <= 32'h00000000;
    else if (bus_req && !we_i)
      dat_q <= rd_mux;
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // ---------------------------------------------------------------
  // perpendicular mode command state
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (hw_rst || sw_rst)
    begin
      write_gate_timing_select_q <= 1'b0;
      gap_select_q <= 1'b0;
    end
    else if (wr_perp)
    begin
      write_gate_timing_select_q <= dat_i[fdc_perp_pkg::PERP_WRITE_GATE_TIMING_SELECT_BIT];
      gap_select_q <= dat_i[fdc_perp_pkg::PERP_GAP_BIT];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (hw_rst)
      per_drive_perp_bits_q <= 4'h0;
    else if (wr_perp && ow_set)
      per_drive_perp_bits_q <= dat_i[fdc_perp_pkg::PERP_DRV_LSB +: 4];
  end

  // ---------------------------------------------------------------
  // lock and configure settings
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (hw_rst)
      lock_q <= 1'b0;
    else if (wr_lock)
      lock_q <= dat_i[fdc_perp_pkg::LOCK_CMD_BIT];
  end

  always_ff @(posedge clk_i)
  begin
    if (cfg_default)
    begin
      fifo_disable_setting_q <= fdc_perp_pkg::FIFO_DIS_RST;
      fifo_threshold_setting_q <= fdc_perp_pkg::FIFO_THR_RST;
    end
    else if (wr_cfg_lo)
    begin
      fifo_disable_setting_q <= dat_i[fdc_perp_pkg::CFG_FIFO_DIS_BIT];
      fifo_threshold_setting_q <= dat_i[fdc_perp_pkg::CFG_THR_LSB +: 4];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (cfg_default)
      precomp_start_track_q <= fdc_perp_pkg::PRECOMP_START_TRACK_RST;
    else if (wr_cfg_hi)
      precomp_start_track_q <= dat_i[fdc_perp_pkg::CFG_PRECOMP_START_TRACK_LSB +: 8];
  end

  // data rate kept apart from the mode; software keeps them matched
  always_ff @(posedge clk_i)
  begin
    if (hw_rst)
    begin
      rate_q <= fdc_perp_pkg::RATE_RST;
      precomp_q <= fdc_perp_pkg::PRECOMP_RST;
    end
    else if (wr_rate)
    begin
      rate_q <= dat_i[fdc_perp_pkg::RATE_LSB +: 2];
      precomp_q <= dat_i[fdc_perp_pkg::PRECOMP_LSB +: 3];
    end
  end

  // ---------------------------------------------------------------
  // compatibility mode caught after hardware reset release
  // ---------------------------------------------------------------
  wire [1:0] compat_sel = identity_select_i ? fdc_perp_pkg::COMPAT_AT :
    (encoding_mode_select_i ? fdc_perp_pkg::COMPAT_PS : fdc_perp_pkg::COMPAT_M30);

  always_ff @(posedge clk_i)
  begin
    hw_rst_q <= hw_rst;
    if (hw_rst)
      compat_q <= fdc_perp_pkg::COMPAT_AT;
    else if (hw_rst_q)
      compat_q <= compat_sel;
  end

  assign compat_mode_o = compat_q;

  // ---------------------------------------------------------------
  // mode decode and timing
  // ---------------------------------------------------------------
  fdc_mode_decode u_decode (
    .write_gate_timing_select_i(write_gate_timing_select_q),
    .gap_i(gap_select_q),
    .drive_perp_i(per_drive_perp_bits_q[0]),
    .rate_i(rate_q),
    .precomp_i(precomp_q),
    .mode_o(mode_d),
    .drive_active_o(drive_active_d),
    .timing_o(timing_d)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      timing_q <= '0;
    else
      timing_q <= timing_d;
  end

  assign gap2_len_o = timing_q.gap2_len;
  assign precomp_o = timing_q.precomp;
  assign fifo_disable_setting_o = fifo_disable_setting_q;
  assign fifo_threshold_setting_o = fifo_threshold_setting_q;
  assign precomp_start_track_o = precomp_start_track_q;

  fdc_gap2_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .gap_start_i(gap_start_i),
    .byte_tick_i(byte_tick_i),
    .read_op_i(read_op_i),
    .write_op_i(write_op_i),
    .op_done_i(op_done_i),
    .timing_i(timing_d),
    .pll_vco_enable_o(pll_vco_enable_o),
    .write_gate_o(write_gate_o)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  hw_reset_clears_a: assert property (
    hardware_reset_pin_i |=> !write_gate_timing_select_q && !gap_select_q
      && per_drive_perp_bits_q == 4'h0 && !lock_q)
    else $error("hardware reset left perpendicular or lock state");
  sw_reset_keeps_a: assert property (
    sw_rst && !hardware_reset_pin_i |=> !write_gate_timing_select_q && !gap_select_q
      && per_drive_perp_bits_q == $past(per_drive_perp_bits_q))
    else $error("software reset mishandled perpendicular bits");
  lock_keeps_cfg_a: assert property (
    sw_rst && lock_q && !hardware_reset_pin_i |=> $stable(precomp_start_track_q)
      && $stable(fifo_disable_setting_q) && $stable(fifo_threshold_setting_q))
    else $error("locked settings changed on software reset");
  unlock_defaults_a: assert property (
    sw_rst && !lock_q |=> fifo_disable_setting_q && fifo_threshold_setting_q == 4'h0
      && precomp_start_track_q == 8'h00)
    else $error("unlocked software reset missed defaults");
  lock_result_a: assert property (
    bus_req && !we_i && hit_lock && !hardware_reset_pin_i
      |=> dat_o[fdc_perp_pkg::LOCK_RES_BIT] == lock_q)
    else $error("lock result byte does not show lock bit");
  ow_guard_a: assert property (
    wr_perp && !ow_set && !hardware_reset_pin_i |=> $stable(per_drive_perp_bits_q))
    else $error("drive bits changed without overwrite enable");
  global_ignore_a: assert property (
    (write_gate_timing_select_q || gap_select_q) |-> !drive_active_d)
    else $error("drive bit used under global select");
  perp_precomp_a: assert property (
    drive_active_d && !hardware_reset_pin_i |=> precomp_o == 3'h0)
    else $error("perpendicular drive got precompensation");
  conv_precomp_a: assert property (
    !drive_active_d |=> precomp_o == $past(precomp_q))
    else $error("conventional drive lost precompensation");
  format_gap_a: assert property (
    write_gate_timing_select_q && !gap_select_q && !per_drive_perp_bits_q[0]
      |=> gap2_len_o == 6'h16)
    else $error("reserved select did not act conventional");
  format_p1m_a: assert property (
    write_gate_timing_select_q && gap_select_q |=> gap2_len_o == 6'h29)
    else $error("1 Mbps perpendicular gap2 length wrong");
  lock_set_a: assert property (
    wr_lock && !hardware_reset_pin_i |=> lock_q == $past(dat_i[fdc_perp_pkg::LOCK_CMD_BIT]))
    else $error("lock bit not taken from command");
  hw_cfg_defaults_a: assert property (
    hardware_reset_pin_i |=> fifo_disable_setting_q && fifo_threshold_setting_q == 4'h0
      && precomp_start_track_q == 8'h00)
    else $error("hardware reset missed fifo defaults");
  compat_strap_a: assert property (
    hw_rst_q && !hw_rst |=> compat_q == $past(compat_sel))
    else $error("compatibility mode not taken from straps");
  rate_keep_a: assert property (
    sw_rst && !hardware_reset_pin_i |=> $stable(rate_q) && $stable(precomp_q))
    else $error("software reset altered the data rate");
  sel_guard_a: assert property (
    bus_req && we_i && !sel_i[0] && hit_perp && !hardware_reset_pin_i
      |=> $stable(write_gate_timing_select_q) && $stable(gap_select_q))
    else $error("perpendicular write without byte enable took effect");

  // ---------------------------------------------------------------
  // scenario covers
  // ---------------------------------------------------------------
  cov_p1m_write: cover property (mode_d == fdc_perp_pkg::MODE_P1M && write_gate_o);
  cov_drive_perp: cover property (drive_active_d ##1 pll_vco_enable_o);
  cov_locked_rst: cover property (lock_q && sw_rst);
  cov_lock_read: cover property (bus_req && !we_i && hit_lock && lock_q);
  cov_reserved: cover property (write_gate_timing_select_q && !gap_select_q);
endmodule : fdc_perpendicular_lock_ctrl

// ==== logic/fdc_perp_pkg.sv ====
// constants and carriers for the perpendicular mode and lock controller
package fdc_perp_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_PERP = 8'h00;
  localparam logic [7:0] OFS_LOCK = 8'h04;
  localparam logic [7:0] OFS_CONFIG = 8'h08;
  localparam logic [7:0] OFS_RATE = 8'h0C;
  localparam logic [7:0] OFS_SWRST = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_DUMP8 = 8'h18;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int PERP_WRITE_GATE_TIMING_SELECT_BIT = 0;
  localparam int PERP_GAP_BIT = 1;
  localparam int PERP_DRV_LSB = 2;
  localparam int PERP_OW_BIT = 7;
  localparam int LOCK_CMD_BIT = 7;
  localparam int LOCK_RES_BIT = 4;
  localparam int CFG_THR_LSB = 0;
  localparam int CFG_FIFO_DIS_BIT = 4;
  localparam int CFG_PRECOMP_START_TRACK_LSB = 8;
  localparam int RATE_LSB = 0;
  localparam int PRECOMP_LSB = 2;
  localparam int SWRST_DOR_BIT = 0;
  localparam int SWRST_DSR_BIT = 1;

  // ---------------------------------------------------------------
  // values after reset, plus the 1 Mbps rate code and no-precompensation value
  // ---------------------------------------------------------------
  localparam logic FIFO_DIS_RST = 1'b1;
  localparam logic [3:0] FIFO_THR_RST = 4'h0;
  localparam logic [7:0] PRECOMP_START_TRACK_RST = 8'h00;
  localparam logic [1:0] RATE_RST = 2'h0;
  localparam logic [2:0] PRECOMP_RST = 3'h0;
  localparam logic [1:0] RATE_1M = 2'h3;
  localparam logic [2:0] PRECOMP_NONE = 3'h0;

  // ---------------------------------------------------------------
  // byte counts within the gap2 field
  // ---------------------------------------------------------------
  localparam logic [5:0] GAP2_CONV_LEN = 6'h16;
  localparam logic [5:0] GAP2_P1M_LEN = 6'h29;
  localparam logic [5:0] WRITTEN_P1M = 6'h26;
  localparam logic [5:0] WRITTEN_P500 = 6'h13;
  localparam logic [5:0] VCO_CONV = 6'h18;
  localparam logic [5:0] VCO_P1M = 6'h2B;
  localparam logic [5:0] WG_CONV = GAP2_CONV_LEN;
  localparam logic [5:0] WG_P1M = GAP2_P1M_LEN - WRITTEN_P1M;
  localparam logic [5:0] WG_P500 = GAP2_CONV_LEN - WRITTEN_P500;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_CONV = 3'b001,
    MODE_P500 = 3'b010,
    MODE_P1M = 3'b100
  } rec_mode_e;

  typedef enum logic [1:0] {
    COMPAT_AT = 2'h0,
    COMPAT_PS = 2'h1,
    COMPAT_M30 = 2'h2
  } compat_mode_e;

  typedef struct packed {
    logic [5:0] vco_point;
    logic [5:0] wg_point;
    logic [5:0] gap2_len;
    logic [2:0] precomp;
  } timing_s;

endpackage : fdc_perp_pkg

// ==== logic/fdc_mode_decode.sv ====
// effective recording mode and gap2 timing from the selects
`timescale 1ns/1ps
module fdc_mode_decode (
  input wire logic write_gate_timing_select_i,
  input wire logic gap_i,
  input wire logic drive_perp_i,
  input wire logic [1:0] rate_i,
  input wire logic [2:0] precomp_i,
  output fdc_perp_pkg::rec_mode_e mode_o,
  output logic drive_active_o,
  output fdc_perp_pkg::timing_s timing_o
);
  wire global_any = write_gate_timing_select_i | gap_i;
  wire rate_1m = (rate_i == fdc_perp_pkg::RATE_1M);
  // per-drive bit only counts in conventional global mode
  assign drive_active_o = ~global_any & drive_perp_i;

  always_comb
  begin
    if (drive_active_o)
      mode_o = rate_1m ? fdc_perp_pkg::MODE_P1M : fdc_perp_pkg::MODE_P500;
    else if (write_gate_timing_select_i & gap_i)
      mode_o = fdc_perp_pkg::MODE_P1M;
    else if (gap_i)
      mode_o = fdc_perp_pkg::MODE_P500;
    else
      mode_o = fdc_perp_pkg::MODE_CONV;
  end

  always_comb
  begin
    timing_o.precomp = drive_active_o ? fdc_perp_pkg::PRECOMP_NONE : precomp_i;
    unique case (mode_o)
      fdc_perp_pkg::MODE_P1M:
      begin
        timing_o.vco_point = fdc_perp_pkg::VCO_P1M;
        timing_o.wg_point = fdc_perp_pkg::WG_P1M;
        timing_o.gap2_len = fdc_perp_pkg::GAP2_P1M_LEN;
      end
      fdc_perp_pkg::MODE_P500:
      begin
        timing_o.vco_point = fdc_perp_pkg::VCO_CONV;
        timing_o.wg_point = fdc_perp_pkg::WG_P500;
        timing_o.gap2_len = fdc_perp_pkg::GAP2_CONV_LEN;
      end
      default:
      begin
        timing_o.vco_point = fdc_perp_pkg::VCO_CONV;
        timing_o.wg_point = fdc_perp_pkg::WG_CONV;
        timing_o.gap2_len = fdc_perp_pkg::GAP2_CONV_LEN;
      end
    endcase
  end
endmodule : fdc_mode_decode

// ==== logic/fdc_gap2_timer.sv ====
// byte counter over gap2 driving vco enable and write gate
`timescale 1ns/1ps
module fdc_gap2_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic gap_start_i,
  input wire logic byte_tick_i,
  input wire logic read_op_i,
  input wire logic write_op_i,
  input wire logic op_done_i,
  input fdc_perp_pkg::timing_s timing_i,
  output logic pll_vco_enable_o,
  output logic write_gate_o
);
  logic active_q;
  logic [5:0] cnt_q;
  wire cnt_max = (cnt_q == 6'h3F);
  wire vco_due = active_q & read_op_i & (cnt_q >= timing_i.vco_point);
  wire wg_due = active_q & write_op_i & (cnt_q >= timing_i.wg_point);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || op_done_i)
      active_q <= 1'b0;
    else if (gap_start_i)
      active_q <= 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || gap_start_i)
      cnt_q <= 6'h00;
    else if (active_q && byte_tick_i && !cnt_max)
      cnt_q <= cnt_q + 6'h01;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || op_done_i)
    begin
      pll_vco_enable_o <= 1'b0;
      write_gate_o <= 1'b0;
    end
    else
    begin
      pll_vco_enable_o <= vco_due;
      write_gate_o <= wg_due;
    end
  end

  vco_point_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(pll_vco_enable_o) |-> $past(cnt_q) == $past(timing_i.vco_point))
    else $error("vco enable rose off its byte point");
  wg_point_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(write_gate_o) |-> $past(cnt_q) == $past(timing_i.wg_point))
    else $error("write gate rose off its byte point");
endmodule : fdc_gap2_timer

// ==== sim/fdc_media_model.sv ====
// floppy drive media side: gap2 byte ticks and capture of gate points
`timescale 1ns/1ps
module fdc_media_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic rd_i,
  input wire logic [3:0] gap_i,
  input wire logic pll_vco_enable_i,
  input wire logic write_gate_i,
  output logic gap_start_o,
  output logic byte_tick_o,
  output logic read_op_o,
  output logic write_op_o,
  output logic op_done_o,
  output logic busy_o,
  output logic [5:0] vco_byte_o,
  output logic [5:0] wg_byte_o
);
  // ---------------------------------------------------------------
  // gap2 field walk, 48 bytes then end of field
  // ---------------------------------------------------------------
  logic [5:0] cnt_q;
  logic [3:0] wait_q;
  logic vco_seen_q;
  logic wg_seen_q;

  always_ff @(posedge clk_i)
  begin
    gap_start_o <= 1'b0;
    byte_tick_o <= 1'b0;
    op_done_o <= 1'b0;
    if (rst_i)
    begin
      busy_o <= 1'b0;
      read_op_o <= 1'b0;
      write_op_o <= 1'b0;
      cnt_q <= 6'h00;
      wait_q <= 4'h0;
      vco_seen_q <= 1'b0;
      wg_seen_q <= 1'b0;
      vco_byte_o <= 6'h3F;
      wg_byte_o <= 6'h3F;
    end
    else if (start_i && !busy_o)
    begin
      busy_o <= 1'b1;
      read_op_o <= rd_i;
      write_op_o <= !rd_i;
      gap_start_o <= 1'b1;
      cnt_q <= 6'h00;
      wait_q <= gap_i;
      vco_seen_q <= 1'b0;
      wg_seen_q <= 1'b0;
      vco_byte_o <= 6'h3F;
      wg_byte_o <= 6'h3F;
    end
    else if (busy_o)
    begin
      if (byte_tick_o)
        cnt_q <= cnt_q + 6'h01;
      if (pll_vco_enable_i && !vco_seen_q)
      begin
        vco_seen_q <= 1'b1;
        vco_byte_o <= cnt_q;
      end
      if (write_gate_i && !wg_seen_q)
      begin
        wg_seen_q <= 1'b1;
        wg_byte_o <= cnt_q;
      end
      if (op_done_o)
      begin
        busy_o <= 1'b0;
        read_op_o <= 1'b0;
        write_op_o <= 1'b0;
      end
      else if (cnt_q == 6'h30)
        op_done_o <= 1'b1;
      else if (wait_q == 4'h0)
      begin
        byte_tick_o <= 1'b1;
        wait_q <= gap_i;
      end
      else
        wait_q <= wait_q - 4'h1;
    end
  end
endmodule : fdc_media_model

// ==== sim/test_fdc_perpendicular_lock_ctrl.sv ====
// self-checking bench for the perpendicular mode and lock controller
`timescale 1ns/1ps
module test_fdc_perpendicular_lock_ctrl;
  typedef struct packed {
    logic [7:0] perp;
    logic [7:0] rate;
    logic [5:0] gap2;
    logic [2:0] pre;
    logic [5:0] vco;
    logic [5:0] wg;
    logic [7:0] dump;
  } row_s;
  row_s rows [9] = '{
    '{8'h00, 8'h14, 6'h16, 3'h5, 6'h18, 6'h16, 8'h00},
    '{8'h02, 8'h00, 6'h16, 3'h0, 6'h18, 6'h03, 8'h02},
    '{8'h03, 8'h03, 6'h29, 3'h0, 6'h2B, 6'h03, 8'h03},
    '{8'h01, 8'h14, 6'h16, 3'h5, 6'h18, 6'h16, 8'h01},
    '{8'h84, 8'h17, 6'h29, 3'h0, 6'h2B, 6'h03, 8'h04},
    '{8'h84, 8'h14, 6'h16, 3'h0, 6'h18, 6'h03, 8'h04},
    '{8'h87, 8'h03, 6'h29, 3'h0, 6'h2B, 6'h03, 8'h07},
    '{8'h80, 8'h14, 6'h16, 3'h5, 6'h18, 6'h16, 8'h00},
    '{8'h04, 8'h14, 6'h16, 3'h5, 6'h18, 6'h16, 8'h00}};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic hw = 1'b0;
  logic ident = 1'b0;
  logic enc = 1'b0;
  logic start = 1'b0;
  logic rd_sel = 1'b0;
  logic [3:0] gap_sel = 4'h1;
  logic [31:0] dat_o;
  logic ack_o, gs, bt, rop, wop, done, busy, vco_o, wg_o, fifo_dis;
  logic [5:0] gap2_len_o, vco_byte, wg_byte;
  logic [2:0] precomp_o;
  logic [3:0] thr;
  logic [7:0] trk;
  logic [1:0] compat;
  logic [31:0] r;
  int n_errors = 0;
  int num_checks = 0;

  fdc_perpendicular_lock_ctrl fdc_perpendicular_lock_ctrl_i (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
    .dat_o(dat_o), .ack_o(ack_o), .hardware_reset_pin_i(hw), .identity_select_i(ident),
    .encoding_mode_select_i(enc), .gap_start_i(gs), .byte_tick_i(bt), .read_op_i(rop),
    .write_op_i(wop), .op_done_i(done), .pll_vco_enable_o(vco_o), .write_gate_o(wg_o),
    .gap2_len_o(gap2_len_o), .precomp_o(precomp_o), .fifo_disable_setting_o(fifo_dis),
    .fifo_threshold_setting_o(thr), .precomp_start_track_o(trk), .compat_mode_o(compat));

  fdc_media_model fdc_media_model_i (.clk_i(clk_i), .rst_i(rst_i), .start_i(start),
    .rd_i(rd_sel), .gap_i(gap_sel), .pll_vco_enable_i(vco_o), .write_gate_i(wg_o),
    .gap_start_o(gs), .byte_tick_o(bt), .read_op_o(rop), .write_op_o(wop), .op_done_o(done),
    .busy_o(busy), .vco_byte_o(vco_byte), .wg_byte_o(wg_byte));

  // ---------------------------------------------------------------
  // clock, watchdog and shared tasks
  // ---------------------------------------------------------------
  always #2.5 clk_i = ~clk_i;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    finish_test();
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do
    begin
      @(posedge clk_i);
    end
    while (ack_o !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'hF, q);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string what);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hF, q);
    check(what, q, e);
  endtask : rdc

  task automatic media(input logic rd, input logic [3:0] g);
    int n;
    n = 0;
    start <= 1'b1;
    rd_sel <= rd;
    gap_sel <= g;
    @(posedge clk_i);
    start <= 1'b0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (busy !== 1'b0 && n < 1000);
    if (n >= 1000)
      n_errors++;
  endtask : media

  task automatic cfg_check(input logic fd, input logic [3:0] t, input logic [7:0] k);
    check("fifo_dis", fifo_dis, fd);
    check("fifo_thr", thr, t);
    check("track", trk, k);
  endtask : cfg_check

  // ---------------------------------------------------------------
  // mode table, then resets, lock and refused accesses
  // ---------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[k])
    begin
      wr(fdc_perp_pkg::OFS_PERP, {24'h0, rows[k].perp});
      wr(fdc_perp_pkg::OFS_RATE, {24'h0, rows[k].rate});
      rdc(fdc_perp_pkg::OFS_DUMP8, {24'h0, rows[k].dump}, "dump8");
      check("gap2_len", gap2_len_o, rows[k].gap2);
      check("precomp", precomp_o, rows[k].pre);
      media(1'b1, k[0] ? 4'h4 : 4'h1);
      check("vco_byte", vco_byte, rows[k].vco);
      media(1'b0, k[0] ? 4'h1 : 4'h4);
      check("wg_byte", wg_byte, rows[k].wg);
      $display("row %0d done", k);
    end
    wr(fdc_perp_pkg::OFS_PERP, 32'h87);
    wr(fdc_perp_pkg::OFS_CONFIG, 32'h0507);
    wr(fdc_perp_pkg::OFS_SWRST, 32'h01);
    rdc(fdc_perp_pkg::OFS_DUMP8, 32'h04, "soft dump");
    cfg_check(1'b1, 4'h0, 8'h00);
    wr(fdc_perp_pkg::OFS_LOCK, 32'h80);
    rdc(fdc_perp_pkg::OFS_LOCK, 32'h10, "lock result");
    wr(fdc_perp_pkg::OFS_PERP, 32'h03);
    wr(fdc_perp_pkg::OFS_CONFIG, 32'h0507);
    wr(fdc_perp_pkg::OFS_SWRST, 32'h02);
    rdc(fdc_perp_pkg::OFS_DUMP8, 32'h84, "locked dump");
    cfg_check(1'b0, 4'h7, 8'h05);
    check("gap2 soft", gap2_len_o, 6'h16);
    $display("soft reset and lock done");
    wb(1'b1, fdc_perp_pkg::OFS_PERP, 32'h83, 4'hE, r);
    wb(1'b1, 8'hFC, 32'hFF, 4'hF, r);
    rdc(8'hFC, 32'h0, "unmapped");
    rdc(fdc_perp_pkg::OFS_DUMP8, 32'h84, "sel dump");
    $display("refused accesses done");
    ident <= 1'b1;
    enc <= 1'b1;
    hw <= 1'b1;
    repeat (2) @(posedge clk_i);
    hw <= 1'b0;
    rdc(fdc_perp_pkg::OFS_DUMP8, 32'h00, "hw dump");
    cfg_check(1'b1, 4'h0, 8'h00);
    check("compat", compat, fdc_perp_pkg::COMPAT_AT);
    $display("hardware reset pin done");
    wr(fdc_perp_pkg::OFS_PERP, 32'h87);
    rst_i <= 1'b1;
    ident <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(fdc_perp_pkg::OFS_DUMP8, 32'h00, "rst dump");
    check("gap2 rst", gap2_len_o, 6'h16);
    check("precomp rst", precomp_o, 3'h0);
    check("compat rst", compat, fdc_perp_pkg::COMPAT_PS);
    $display("reset done");
    finish_test();
  end
endmodule : test_fdc_perpendicular_lock_ctrl
